/* logic/converter_fault_pkg.sv */
package converter_fault_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_NS       = 100000;
  localparam logic [11:0] TICK_CYCLES   = 12'(TICK_NS / CLK_PERIOD_NS);

  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CFG_BASE = 8'h04;
  localparam logic [7:0] ADDR_SEQ      = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;

  localparam int unsigned CTRL_RUN_BIT     = 0;
  localparam int unsigned CTRL_DE_BIT      = 1;
  localparam int unsigned CTRL_RESTART_BIT = 2;

  localparam int unsigned LOW_LSB   = 0;
  localparam int unsigned RESP_LSB  = 12;
  localparam int unsigned RETRY_LSB = 16;
  localparam int unsigned DLY_LSB   = 20;
  localparam int unsigned TGT_LSB   = 0;
  localparam int unsigned SDLY_LSB  = 12;
  localparam int unsigned REXP_LSB  = 20;
  localparam logic [31:0] CFG_MASK  = 32'h0FFF7FFF;
  localparam logic [31:0] SEQ_MASK  = 32'h007FFFFF;

  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CH_UV  = 0;
  localparam int unsigned CH_OV  = 1;
  localparam int unsigned CH_OC  = 2;
  localparam int unsigned CH_OT  = 3;

  // Per channel: delay, retries, response, low field (threshold/percent/limit)
  localparam logic [3:0][31:0] CFG_RST = {32'h00A3007D, 32'h00A30000,
                                          32'h00A3000F, 32'h00A3011D};
  localparam logic [31:0] SEQ_RST = 32'h00414078;

  localparam logic [11:0] UV_THR_MIN = 12'h11D;
  localparam logic [11:0] UV_THR_MAX = 12'h640;
  localparam logic [7:0]  PCT_FULL   = 8'h64;
  localparam logic [7:0]  OT_HYST    = 8'h0F;

  localparam int unsigned PIN_W       = 6;
  localparam int unsigned PIN_EN      = 0;
  localparam int unsigned PIN_OC      = 1;
  localparam int unsigned PIN_LOWLOAD = 2;
  localparam int unsigned PIN_SYNC    = 3;
  localparam int unsigned PIN_MULTI   = 4;
  localparam int unsigned PIN_SHARE   = 5;

  typedef enum logic [2:0] {
    RESP_SHUT_MON  = 3'h0,
    RESP_IGNORE    = 3'h1,
    RESP_DELAY_OFF = 3'h2,
    RESP_RETRY_N   = 3'h3,
    RESP_RETRY_INF = 3'h4,
    RESP_CROWBAR   = 3'h5
  } resp_type;

  typedef enum logic [3:0] {
    CH_RUN   = 4'h1,
    CH_GRACE = 4'h2,
    CH_HOLD  = 4'h4,
    CH_LATCH = 4'h8
  } ch_state_type;

  typedef enum logic [5:0] {
    PWR_OFF    = 6'h01,
    PWR_DELAY  = 6'h02,
    PWR_SAMPLE = 6'h04,
    PWR_RAMP   = 6'h08,
    PWR_DOWN   = 6'h10,
    PWR_REG    = 6'h20
  } pwr_state_type;

endpackage : converter_fault_pkg

/* logic/fault_response_channel.sv */
module fault_response_channel #(
  parameter int unsigned RETRY_W = 4,
  parameter int unsigned DELAY_W = 8
) (
  // Clock and reset
  input  logic                          core_clk,
  input  logic                          rst,
  // Fault condition and configuration
  input  logic                          tick,
  input  logic                          fault,
  input  logic                          fault_clear,
  input  converter_fault_pkg::resp_type resp,
  input  logic [RETRY_W-1:0]            retry_limit,
  input  logic [DELAY_W-1:0]            delay_ticks,
  // Restart command and regulation status
  input  logic                          restart,
  input  logic                          reload,
  // Response
  output logic                          shut_off,
  output logic                          crowbar
);
  import converter_fault_pkg::*;

  ch_state_type       state_ff;
  ch_state_type       nxt_state;
  logic [DELAY_W-1:0] timer_ff;
  logic [DELAY_W-1:0] nxt_timer;
  logic [RETRY_W-1:0] used_ff;
  logic [RETRY_W-1:0] nxt_used;
  logic               crowbar_ff;
  logic               nxt_crowbar;

  wire timer_zero = (timer_ff == '0);
  wire exhausted  = (used_ff >= retry_limit);

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_timer   = timer_ff;
    nxt_used    = used_ff;
    nxt_crowbar = crowbar_ff;
    unique case (state_ff)
      CH_RUN:
      begin
        if (reload)
          nxt_used = '0;
        if (fault)
        begin
          unique case (resp)
            RESP_IGNORE:
              nxt_state = CH_RUN;
            RESP_DELAY_OFF:
            begin
              nxt_state = CH_GRACE;
              nxt_timer = delay_ticks;
            end
            RESP_CROWBAR:
            begin
              nxt_state   = CH_LATCH;
              nxt_crowbar = 1'b1;
            end
            RESP_RETRY_N:
            begin
              nxt_state = exhausted ? CH_LATCH : CH_HOLD;
              nxt_timer = delay_ticks;
            end
            RESP_RETRY_INF:
            begin
              nxt_state = CH_HOLD;
              nxt_timer = delay_ticks;
            end
            default:
            begin
              nxt_state = CH_HOLD;
              nxt_timer = '0;
            end
          endcase
        end
      end
      CH_GRACE:
      begin
        if (!fault)
          nxt_state = CH_RUN;
        else if (tick && timer_zero)
          nxt_state = CH_LATCH;
        else if (tick)
          nxt_timer = timer_ff - 1'b1;
      end
      CH_HOLD:
      begin
        if (!timer_zero)
        begin
          if (tick)
            nxt_timer = timer_ff - 1'b1;
        end
        else if (fault_clear)
        begin
          nxt_state = CH_RUN;
          if (resp == RESP_RETRY_N)
            nxt_used = used_ff + 1'b1;
        end
        else if (resp != RESP_SHUT_MON)
          nxt_timer = delay_ticks;
      end
      CH_LATCH:
      begin
        if (restart)
        begin
          nxt_state   = CH_RUN;
          nxt_crowbar = 1'b0;
          nxt_used    = '0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff   <= CH_RUN;
      timer_ff   <= '0;
      used_ff    <= '0;
      crowbar_ff <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      timer_ff   <= nxt_timer;
      used_ff    <= nxt_used;
      crowbar_ff <= nxt_crowbar;
    end
  end

  assign shut_off = (state_ff == CH_HOLD) || (state_ff == CH_LATCH);
  assign crowbar  = crowbar_ff;

endmodule : fault_response_channel

/* logic/converter_fault_supervisor.sv */
// Notes on behaviour
// - Diode emulation at low load turns the low-side gate off.
// - Diode emulation only works in single-phase operation.
// - Input low threshold programmable 2.85 V to 16 V; start inhibited below it.
// - Input low fault: ignore, delayed latch-off, or shutdown with retries.
// - Input low default: immediate shutdown, auto re-enable when cleared.
// - Overvoltage flag: output above target plus percentage, default 15 %.
// - Power-good drops before the overvoltage response acts.
// - Overvoltage crowbar: high-side off, low-side on until restart.
// - Overvoltage default: immediate shutdown, auto re-enable when cleared.
// - With external sync, an overvoltage crowbar response is forced to shutdown.
// - Output is sampled for prebias before the ramp starts.
// - Prebias below target: ramp from prebias within the configured ramp time.
// - Prebias above target: hold duty, power-good after ramp, then ramp down.
// - Prebias above overvoltage limit: no turn-on, overvoltage fault applies.
// - Prebias handling is off for sharing groups with tracking.
// - Overcurrent offers five responses: retry forever/N, delay-off, ignore, shut.
// - Overcurrent default: immediate shutdown, auto re-enable when cleared.
// - Temperature above programmable limit, default 125, shuts down.
// - Temperature fault offers the same five responses.
// - Thermal restart needs temperature below limit minus 15 after delay.
// - Thermal default: immediate shutdown, auto re-enable when cleared.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
module converter_fault_supervisor #(
  parameter int unsigned RETRY_W = 4,
  parameter int unsigned DELAY_W = 8
) (
  // Clock and reset
  input  logic        core_clk,
  input  logic        rst,
  // APB slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Asynchronous pins
  input  logic        enable_pin,
  input  logic        overcurrent_pin,
  input  logic        low_load_pin,
  input  logic        ext_sync_pin,
  input  logic        multi_phase_pin,
  input  logic        share_track_pin,
  // Converter measurements, same clock
  input  logic [11:0] vin_code,
  input  logic [11:0] output_sense_positive,
  input  logic [7:0]  temp_code,
  // Drive decisions
  output logic        high_side_enable,
  output logic        low_side_enable,
  output logic        output_good_flag,
  output logic [11:0] working_target,
  output logic        prebias_duty_hold,
  output logic        input_low_lockout
);
  import converter_fault_pkg::*;

  function automatic logic ov_exceeds(input logic [11:0] v, input logic [11:0] tgt,
                                      input logic [7:0] pct);
    ov_exceeds = (22'(v) * 22'(PCT_FULL)) > (22'(tgt) * (22'(PCT_FULL) + 22'(pct)));
  endfunction : ov_exceeds

  logic [PIN_W-1:0] pin_s1_ff;
  logic [PIN_W-1:0] pin_s2_ff;
  logic [PIN_W-1:0] pin_s3_ff;
  logic [PIN_W-1:0] pin_ff;
  logic [1:0]       ctrl_ff;
  logic [31:0]      cfg_ff [NUM_CH];
  logic [31:0]      seq_ff;
  logic [11:0]      tick_cnt_ff;
  pwr_state_type    pwr_ff;
  pwr_state_type    nxt_pwr;
  logic [7:0]       sdly_ff;
  logic [7:0]       nxt_sdly;
  logic [8:0]       ramp_cnt_ff;
  logic [8:0]       nxt_ramp_cnt;
  logic [11:0]      ramp_start_ff;
  logic [11:0]      nxt_ramp_start;
  logic             above_ff;
  logic             nxt_above;
  logic [11:0]      nxt_working;
  logic             ov_fault_ff;
  logic             hs_ff;
  logic             ls_ff;
  logic             pg_ff;
  logic [11:0]      work_ff;
  logic             uvl_ff;
  logic [NUM_CH-1:0] ch_fault;
  logic [NUM_CH-1:0] ch_clear;
  logic [NUM_CH-1:0] ch_off;
  logic [NUM_CH-1:0] ch_crowbar;
  resp_type          ch_resp [NUM_CH];

  // Pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
      pin_ff    <= '0;
    end
    else
    begin
      pin_s1_ff <= {share_track_pin, multi_phase_pin, ext_sync_pin,
                    low_load_pin, overcurrent_pin, enable_pin};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff    <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff ^ pin_s3_ff));
    end
  end

  wire en_s          = pin_ff[PIN_EN];
  wire low_load_s    = pin_ff[PIN_LOWLOAD];
  wire ext_sync_s    = pin_ff[PIN_SYNC];
  wire multi_phase_s = pin_ff[PIN_MULTI];
  wire share_track_s = pin_ff[PIN_SHARE];

  // APB decode
  wire        acc       = psel && penable;
  wire        wr        = acc && pwrite;
  wire        hit_ctrl  = (paddr == ADDR_CTRL);
  wire        hit_seq   = (paddr == ADDR_SEQ);
  wire        hit_stat  = (paddr == ADDR_STATUS);
  wire [7:0]  cfg_off   = paddr - ADDR_CFG_BASE;
  wire        hit_cfg   = (paddr >= ADDR_CFG_BASE) && (paddr < ADDR_SEQ) && (paddr[1:0] == 2'h0);
  wire [1:0]  cfg_idx   = cfg_off[3:2];
  wire        hit_any   = hit_ctrl || hit_seq || hit_stat || hit_cfg;
  wire        restart   = wr && hit_ctrl && pwdata[CTRL_RESTART_BIT];
  wire [11:0] wr_low    = pwdata[LOW_LSB +: 12];
  wire [11:0] uv_clamp  = (wr_low < UV_THR_MIN) ? UV_THR_MIN :
                          (wr_low > UV_THR_MAX) ? UV_THR_MAX : wr_low;
  wire [31:0] cfg_wdata = (cfg_idx == 2'(CH_UV)) ?
                          {pwdata[31:12], uv_clamp} & CFG_MASK : pwdata & CFG_MASK;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_ff <= '0;
      seq_ff  <= SEQ_RST;
      for (int i = 0; i < NUM_CH; i++)
        cfg_ff[i] <= CFG_RST[i];
    end
    else if (wr)
    begin
      if (hit_ctrl)
        ctrl_ff <= pwdata[1:0];
      if (hit_seq)
        seq_ff <= pwdata & SEQ_MASK;
      if (hit_cfg)
        cfg_ff[cfg_idx] <= cfg_wdata;
    end
  end

  wire [11:0] uv_thr    = cfg_ff[CH_UV][LOW_LSB +: 12];
  wire [7:0]  ov_pct    = cfg_ff[CH_OV][LOW_LSB +: 8];
  wire [7:0]  ot_limit  = cfg_ff[CH_OT][LOW_LSB +: 8];
  wire [11:0] target    = seq_ff[TGT_LSB +: 12];
  wire [7:0]  start_dly = seq_ff[SDLY_LSB +: 8];
  wire [2:0]  ramp_exp  = seq_ff[REXP_LSB +: 3];
  wire        run_cmd   = ctrl_ff[CTRL_RUN_BIT];
  wire        de_active = ctrl_ff[CTRL_DE_BIT] && !multi_phase_s;

  // Fault detectors
  wire       uv_fault = (vin_code < uv_thr);
  wire       ov_flag  = ov_exceeds(output_sense_positive, target, ov_pct);
  wire       ot_fault = (temp_code > ot_limit);
  wire [7:0] ot_low   = (ot_limit > OT_HYST) ? ot_limit - OT_HYST : 8'h00;
  wire       ot_clear = (temp_code < ot_low);

  assign ch_fault = {ot_fault, pin_ff[PIN_OC], ov_fault_ff, uv_fault};
  assign ch_clear = {ot_clear, !pin_ff[PIN_OC], !ov_flag, !uv_fault};

  wire tick = (tick_cnt_ff == TICK_CYCLES - 12'h001);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tick_cnt_ff <= '0;
    else
      tick_cnt_ff <= tick ? 12'h000 : tick_cnt_ff + 12'h001;
  end

  // One response engine per fault source
  generate
    for (genvar gi = 0; gi < NUM_CH; gi++)
    begin : g_chan
      wire [2:0] raw = cfg_ff[gi][RESP_LSB +: 3];
      wire no_crowbar = (gi != CH_OV) || ext_sync_s;
      assign ch_resp[gi] = (raw == RESP_CROWBAR && no_crowbar) ? RESP_SHUT_MON
                                                                 : resp_type'(raw);
      fault_response_channel #(
        .RETRY_W (RETRY_W),
        .DELAY_W (DELAY_W)
      ) u_chan (
        .core_clk    (core_clk),
        .rst         (rst),
        .tick        (tick),
        .fault       (ch_fault[gi]),
        .fault_clear (ch_clear[gi]),
        .resp        (ch_resp[gi]),
        .retry_limit (cfg_ff[gi][RETRY_LSB +: RETRY_W]),
        .delay_ticks (cfg_ff[gi][DLY_LSB +: DELAY_W]),
        .restart     (restart),
        .reload      (pg_ff),
        .shut_off    (ch_off[gi]),
        .crowbar     (ch_crowbar[gi])
      );
    end
  endgenerate

  wire        any_off  = |ch_off;
  wire        crowbar  = |ch_crowbar;
  wire        start_ok = run_cmd && en_s && !any_off && !uv_fault;
  wire        pb_off   = share_track_s;
  wire [11:0] pb_level = pb_off ? 12'h000 : output_sense_positive;
  wire        pb_ov    = !pb_off && ov_exceeds(output_sense_positive, target, ov_pct);
  wire [8:0]  span     = 9'h001 << ramp_exp;
  wire        ramp_end = tick && (ramp_cnt_ff == span);
  wire signed [12:0] ramp_diff = $signed({1'b0, target}) - $signed({1'b0, ramp_start_ff});
  wire signed [21:0] ramp_prod = 22'(ramp_diff) * $signed({13'h0000, ramp_cnt_ff});
  wire signed [21:0] ramp_step = ramp_prod >>> ramp_exp;
  wire [11:0] ramp_pt  = ramp_start_ff + ramp_step[11:0];

  always_comb
  begin
    nxt_pwr        = pwr_ff;
    nxt_sdly       = sdly_ff;
    nxt_ramp_cnt   = ramp_cnt_ff;
    nxt_ramp_start = ramp_start_ff;
    nxt_above      = above_ff;
    nxt_working    = work_ff;
    unique case (pwr_ff)
      PWR_OFF:
      begin
        nxt_working = '0;
        if (start_ok)
        begin
          nxt_pwr  = PWR_DELAY;
          nxt_sdly = start_dly;
        end
      end
      PWR_DELAY:
      begin
        if (tick && sdly_ff == 8'h00)
          nxt_pwr = PWR_SAMPLE;
        else if (tick)
          nxt_sdly = sdly_ff - 8'h01;
      end
      PWR_SAMPLE:
      begin
        if (pb_ov)
          nxt_pwr = PWR_OFF;
        else
        begin
          nxt_pwr        = PWR_RAMP;
          nxt_ramp_start = pb_level;
          nxt_above      = pb_level > target;
          nxt_ramp_cnt   = '0;
          nxt_working    = pb_level;
        end
      end
      PWR_RAMP:
      begin
        if (tick)
          nxt_ramp_cnt = ramp_cnt_ff + 9'h001;
        nxt_working = above_ff ? ramp_start_ff : ramp_pt;
        if (ramp_end)
        begin
          nxt_pwr      = above_ff ? PWR_DOWN : PWR_REG;
          nxt_ramp_cnt = '0;
        end
      end
      PWR_DOWN:
      begin
        if (tick)
          nxt_ramp_cnt = ramp_cnt_ff + 9'h001;
        nxt_working = ramp_pt;
        if (ramp_end)
          nxt_pwr = PWR_REG;
      end
      PWR_REG:
        nxt_working = target;
    endcase
    if (pwr_ff != PWR_OFF && !(run_cmd && en_s && !any_off))
      nxt_pwr = PWR_OFF;
  end

  wire gates_on = (pwr_ff == PWR_RAMP) || (pwr_ff == PWR_DOWN) || (pwr_ff == PWR_REG);
  wire pg_nxt   = ((pwr_ff == PWR_DOWN) || (pwr_ff == PWR_REG)) && !ov_flag && !any_off;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pwr_ff        <= PWR_OFF;
      sdly_ff       <= '0;
      ramp_cnt_ff   <= '0;
      ramp_start_ff <= '0;
      above_ff      <= 1'b0;
      work_ff       <= '0;
      ov_fault_ff   <= 1'b0;
      hs_ff         <= 1'b0;
      ls_ff         <= 1'b0;
      pg_ff         <= 1'b0;
      uvl_ff        <= 1'b0;
    end
    else
    begin
      pwr_ff        <= nxt_pwr;
      sdly_ff       <= nxt_sdly;
      ramp_cnt_ff   <= nxt_ramp_cnt;
      ramp_start_ff <= nxt_ramp_start;
      above_ff      <= nxt_above;
      work_ff       <= nxt_working;
      ov_fault_ff   <= ov_flag;
      hs_ff         <= gates_on && !crowbar;
      ls_ff         <= crowbar || (gates_on && !(de_active && low_load_s));
      pg_ff         <= pg_nxt;
      uvl_ff        <= uv_fault;
    end
  end

  assign high_side_enable  = hs_ff;
  assign low_side_enable   = ls_ff;
  assign output_good_flag  = pg_ff;
  assign working_target    = work_ff;
  assign prebias_duty_hold = (pwr_ff == PWR_RAMP) && above_ff;
  assign input_low_lockout = uvl_ff;

  wire [31:0] status = {14'h0000, pwr_ff, ch_crowbar, ch_off,
                        uvl_ff, ls_ff, hs_ff, pg_ff};
  wire [31:0] rd_mux = hit_ctrl ? {30'h00000000, ctrl_ff} :
                       hit_cfg  ? cfg_ff[cfg_idx] :
                       hit_seq  ? seq_ff :
                       hit_stat ? status : 32'h00000000;
  assign prdata  = rd_mux;
  assign pready  = 1'b1;
  assign pslverr = acc && !hit_any;

  property p_de_low_side;
    @(posedge core_clk) disable iff (rst)
      (gates_on && !crowbar && de_active && low_load_s) |=> !low_side_enable;
  endproperty
  a_de_low_side: assert property (p_de_low_side) else $error("low side on in emulation");

  property p_multi_phase;
    @(posedge core_clk) disable iff (rst)
      (gates_on && multi_phase_s) |=> low_side_enable;
  endproperty
  a_multi_phase: assert property (p_multi_phase) else $error("emulation in multi-phase");

  property p_uv_inhibit;
    @(posedge core_clk) disable iff (rst)
      (pwr_ff == PWR_OFF && uv_fault) |=> (pwr_ff == PWR_OFF);
  endproperty
  a_uv_inhibit: assert property (p_uv_inhibit) else $error("start below input threshold");

  property p_pg_first;
    @(posedge core_clk) disable iff (rst)
      ch_off[CH_OV] |-> !output_good_flag;
  endproperty
  a_pg_first: assert property (p_pg_first) else $error("power-good high at ov shutdown");

  property p_crowbar;
    @(posedge core_clk) disable iff (rst)
      crowbar |=> (!high_side_enable && low_side_enable);
  endproperty
  a_crowbar: assert property (p_crowbar) else $error("crowbar gates wrong");

  property p_sync_ov;
    @(posedge core_clk) disable iff (rst)
      $rose(ch_crowbar[CH_OV]) |-> !$past(ext_sync_s, 1);
  endproperty
  a_sync_ov: assert property (p_sync_ov) else $error("crowbar under external sync");

  property p_pb_start;
    @(posedge core_clk) disable iff (rst)
      (pwr_ff == PWR_SAMPLE && !pb_off && !pb_ov && nxt_pwr == PWR_RAMP)
        |=> (ramp_start_ff == $past(output_sense_positive));
  endproperty
  a_pb_start: assert property (p_pb_start) else $error("prebias start level wrong");

  property p_pb_ov;
    @(posedge core_clk) disable iff (rst)
      (pwr_ff == PWR_SAMPLE && pb_ov) |=> (pwr_ff == PWR_OFF) ##1 !high_side_enable;
  endproperty
  a_pb_ov: assert property (p_pb_ov) else $error("turn-on above ov limit");

  property p_pg_ramp;
    @(posedge core_clk) disable iff (rst)
      (pwr_ff == PWR_RAMP) |-> !output_good_flag;
  endproperty
  a_pg_ramp: assert property (p_pg_ramp) else $error("power-good during ramp");

  property p_ot_shut;
    @(posedge core_clk) disable iff (rst)
      (ot_fault && ch_resp[CH_OT] == RESP_SHUT_MON && hs_ff) |-> ##[1:4] !high_side_enable;
  endproperty
  a_ot_shut: assert property (p_ot_shut) else $error("no thermal shutdown");

endmodule : converter_fault_supervisor

/* testbench/plant_model.sv */
module plant_model (
  // Drive decisions from the supervisor
  input  wire logic        high_side_enable,
  input  wire logic [11:0] working_target,
  // Bench override of the sensed output
  input  wire logic        force_en,
  input  wire logic [11:0] force_level,
  // Sensed output
  output logic [11:0]      output_sense_positive
);
  timeunit 1ns;
  timeprecision 1ps;
  // Output follows reference while switching, else discharges
  assign output_sense_positive = force_en ? force_level
                               : (high_side_enable ? working_target : 12'h000);
endmodule : plant_model

/* testbench/tb.sv */
module tb;
  import converter_fault_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] e;} row_type;
  logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        en = 0, oc = 0, ll = 0, mp = 0, fe = 0, zero = 0;
  logic [7:0]  paddr = 8'h00, temp = 8'h19;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [11:0] vin = 12'h200, fl = 12'h090, sense, wt;
  logic        pready, pslverr, er, hs, ls, pg, pdh, lock;
  int          n_errors = 0, cmp_count = 0;
  row_type     rows [7] = '{'{8'h00, 32'h0}, '{8'h04, 32'h00A3011D},
    '{8'h08, 32'h00A3000F}, '{8'h0C, 32'h00A30000}, '{8'h10, 32'h00A3007D},
    '{8'h14, 32'h00414078}, '{8'h18, 32'h00001000}};

  converter_fault_supervisor u_dut (.core_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .enable_pin(en),
    .overcurrent_pin(oc), .low_load_pin(ll), .ext_sync_pin(zero),
    .multi_phase_pin(mp), .share_track_pin(zero), .vin_code(vin),
    .output_sense_positive(sense), .temp_code(temp), .high_side_enable(hs),
    .low_side_enable(ls), .output_good_flag(pg), .working_target(wt),
    .prebias_duty_hold(pdh), .input_low_lockout(lock));
  plant_model u_plant (.high_side_enable(hs), .working_target(wt), .force_en(fe),
    .force_level(fl), .output_sense_positive(sense));

  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1)
      @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Bounded wait for power-good to reach a level
  task automatic wpg(input logic v);
    int i;
    for (i = 0; i < 20000 && pg !== v; i++)
      @(posedge core_clk);
  endtask : wpg

  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    #2400000;
    n_errors++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    foreach (rows[i])
    begin
      apb(1'h0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    apb(1'h0, 8'h1C, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'h1, ADDR_CFG_BASE, 32'h00A30001);
    apb(1'h0, ADDR_CFG_BASE, 32'h0);
    chk(rd, 32'h00A3011D);
    vin <= 12'h100;
    apb(1'h1, ADDR_SEQ, 32'h00000078);
    apb(1'h1, ADDR_CTRL, 32'h1);
    en <= 1'h1;
    repeat (10) @(posedge core_clk);
    chk(32'(lock), 32'h1);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(32'(rd[17:12]), 32'h1);
    vin <= 12'h200;
    wpg(1'h1);
    chk(32'({pg, hs, ls, wt}), 32'h7078);
    apb(1'h1, ADDR_CTRL, 32'h3);
    ll <= 1'h1;
    repeat (10) @(posedge core_clk);
    chk(32'(ls), 32'h0);
    mp <= 1'h1;
    repeat (10) @(posedge core_clk);
    chk(32'(ls), 32'h1);
    mp <= 1'h0;
    ll <= 1'h0;
    // Emulation off before the overvoltage step
    apb(1'h1, ADDR_CTRL, 32'h1);
    fe <= 1'h1;
    wpg(1'h0);
    chk(32'(hs), 32'h1);
    repeat (10) @(posedge core_clk);
    chk(32'(hs), 32'h0);
    fe <= 1'h0;
    wpg(1'h1);
    chk(32'(pg), 32'h1);
    oc <= 1'h1;
    repeat (10) @(posedge core_clk);
    chk(32'(hs), 32'h0);
    oc <= 1'h0;
    wpg(1'h1);
    chk(32'(pg), 32'h1);
    temp <= 8'h80;
    repeat (10) @(posedge core_clk);
    chk(32'(hs), 32'h0);
    temp <= 8'h70;
    repeat (50) @(posedge core_clk);
    chk(32'(hs), 32'h0);
    temp <= 8'h6D;
    wpg(1'h1);
    chk(32'(pg), 32'h1);
    // Restart into an above-target prebias
    apb(1'h1, ADDR_CTRL, 32'h0);
    fl <= 12'h080;
    fe <= 1'h1;
    repeat (10) @(posedge core_clk);
    apb(1'h1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 20000 && pdh !== 1'h1; i++)
      @(posedge core_clk);
    chk(32'({pdh, wt}), 32'h1080);
    wpg(1'h1);
    chk(32'({pg, pdh}), 32'h2);
    fe <= 1'h0;
    finish_test();
  end
endmodule : tb
